/* File: logic/swc_pkg.sv */
// shared constants, field layouts and carrier types of the throw control block
package swc_pkg;

  //////////////////////////////////////////////////////////////////////////////
  // bus geometry
  localparam int          SWC_ADR_W        = 8;       // byte address width seen
  localparam int          SWC_DAT_W        = 32;      // wishbone data width
  localparam int          SWC_SEL_W        = 4;       // byte selects

  //////////////////////////////////////////////////////////////////////////////
  // register byte offsets
  localparam logic [7:0]  SWC_CTRL_OFS     = 8'h20;   // throw control and fault
  localparam logic [7:0]  SWC_STAT_OFS     = 8'h24;   // sticky event status
  localparam logic [7:0]  SWC_MASK_OFS     = 8'h28;   // event mask

  //////////////////////////////////////////////////////////////////////////////
  // field positions and reset values
  localparam int          SWC_CLOSE_LSB    = 0;       // four throw enables
  localparam int          SWC_CLOSE_W      = 4;
  localparam int          SWC_RSVD_LSB     = 4;       // reserved pair
  localparam int          SWC_FAULT_LSB    = 6;       // fault code pair
  localparam int          SWC_FAULT_W      = 2;
  localparam logic [7:0]  SWC_CTRL_RST     = 8'h00;   // control after reset
  localparam logic [1:0]  SWC_FAULT_NONE   = 2'h0;    // code for no fault
  localparam logic [1:0]  SWC_EVT_RST      = 2'h0;    // status and mask reset
  localparam int          SWC_EVT_N        = 2;       // number of events
  localparam int          SWC_EVT_FAULT    = 0;       // fault code turned nonzero
  localparam int          SWC_EVT_RSVDWR   = 1;       // reserved field written nonzero
  localparam int          SWC_SYNC_STAGES  = 2;       // pin synchroniser depth

  //////////////////////////////////////////////////////////////////////////////
  // carriers
  typedef struct packed {
    logic [1:0] fault;                                  // read-only fault code
    logic [1:0] rsvd;                                   // reserved, reads zero
    logic [3:0] close;                                  // throw four..one
  } swc_ctrl_t;

  typedef struct packed {
    logic rsvd_wr;                                      // reserved write seen
    logic fault;                                        // fault onset seen
  } swc_evt_t;

  //////////////////////////////////////////////////////////////////////////////
  // word address match, ignoring the two byte bits
  function automatic logic swc_hit(input logic [7:0] adr, input logic [7:0] ofs);
    swc_hit = (adr[7:2] == ofs[7:2]);
  endfunction

endpackage

/* File: logic/swc_sync.sv */
// multi-stage synchroniser for levels arriving from pins
`timescale 1ns/1ns
module swc_sync
  import swc_pkg::*;
#(
  parameter int W      = 2,                             // bits carried
  parameter int STAGES = SWC_SYNC_STAGES                // flip-flops in chain
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         nrst,
  // asynchronous level in, synchronised level out
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);

  // refuse a chain too short to settle metastability
  if (STAGES < 2) begin : g_chk
    $error("swc_sync needs at least two stages");
  end

  logic [W-1:0] chain_ff [STAGES];                      // stage 0 feeds stage 1 only

  // shift the level along the chain
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < STAGES; i++) begin
        chain_ff[i] <= '0;
      end
    end else begin
      chain_ff[0] <= async_i;
      for (int i = 1; i < STAGES; i++) begin
        chain_ff[i] <= chain_ff[i-1];
      end
    end
  end

  assign sync_o = chain_ff[STAGES-1];

endmodule

/* File: logic/swc_irq.sv */
// sticky event status with read clear, mask and one level interrupt
`timescale 1ns/1ns
module swc_irq
  import swc_pkg::*;
(
  // clock and reset
  input  wire logic     clk,
  input  wire logic     nrst,
  // event pulses, read clear and mask
  input  wire swc_evt_t evt_i,
  input  wire logic     rd_clr_i,
  input  wire swc_evt_t mask_i,
  // status and interrupt
  output swc_evt_t      stat_o,
  output logic          irq_o
);

  swc_evt_t stat_ff;                                    // sticky status
  swc_evt_t nxt_stat;                                   // status after this edge
  logic     irq_ff;                                     // registered interrupt

  // a read clears, a new event in the same cycle still sets
  always_comb begin
    nxt_stat = rd_clr_i ? swc_evt_t'(SWC_EVT_RST) : stat_ff;
    nxt_stat = nxt_stat | evt_i;
  end

  // status register
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      stat_ff <= swc_evt_t'(SWC_EVT_RST);
    end else begin
      stat_ff <= nxt_stat;
    end
  end

  // interrupt follows unmasked status from the same edge
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= |(nxt_stat & mask_i);
    end
  end

  assign stat_o = stat_ff;
  assign irq_o  = irq_ff;

endmodule

/* File: logic/swc_regs.sv */
// four-throw switch control register block on a classic wishbone slave
//
// Operation
// - control register at 0x20, zero after reset
// - bit 0 closes throw one when set
// - bit 1 closes throw two when set
// - bit 2 closes throw three when set
// - bit 3 closes throw four when set
// - bits 7:6 read-only fault code, zero means none
// - bits 5:4 reserved, read zero, host writes zero
`timescale 1ns/1ns
module swc_regs
  import swc_pkg::*;
#(
  parameter int SYNC_STAGES = SWC_SYNC_STAGES           // fault pin sync depth
) (
  // clock and reset
  input  wire logic                 clk,
  input  wire logic                 nrst,
  // wishbone classic slave
  input  wire logic                 wb_cyc_i,
  input  wire logic                 wb_stb_i,
  input  wire logic                 wb_we_i,
  input  wire logic [SWC_ADR_W-1:0] wb_adr_i,
  input  wire logic [SWC_SEL_W-1:0] wb_sel_i,
  input  wire logic [SWC_DAT_W-1:0] wb_dat_i,
  output logic      [SWC_DAT_W-1:0] wb_dat_o,
  output logic                      wb_ack_o,
  // fault code from the switch driver, asynchronous
  input  wire logic [1:0]           fault_code_i,
  // throw drive, high closes the throw
  output logic                      throw_one_close,
  output logic                      throw_two_close,
  output logic                      throw_three_close,
  output logic                      throw_four_close,
  // interrupt, level
  output logic                      irq
);

  // refuse a synchroniser that cannot settle
  if (SYNC_STAGES < 2) begin : g_chk
    $error("swc_regs needs SYNC_STAGES of two or more");
  end

  //////////////////////////////////////////////////////////////////////////////
  // declarations

  logic [3:0]           close_ff;                       // throw enables
  logic [1:0]           fault_q;                        // synchronised fault code
  logic [1:0]           fault_prev_ff;                  // code one cycle earlier
  swc_evt_t             mask_ff;                        // event mask
  swc_evt_t             nxt_mask;                       // mask after this edge
  swc_evt_t             stat;                           // sticky status
  swc_evt_t             evt;                            // event pulses this cycle
  logic                 ack_ff;                         // bus answer
  logic [SWC_DAT_W-1:0] dat_ff;                         // read data
  logic                 req;                            // a bus request stands
  logic                 take;                           // request answered this edge
  logic                 commit;                         // write lands this edge
  logic                 hit_ctrl;                       // address is control word
  logic                 hit_stat;                       // address is status word
  logic                 hit_mask;                       // address is mask word
  logic                 wr_ctrl;                        // control write with lane 0
  logic                 rd_stat_clr;                    // status read completes
  swc_ctrl_t            ctrl_view;                      // control word as read
  logic [SWC_DAT_W-1:0] nxt_dat;                        // read mux result

  //////////////////////////////////////////////////////////////////////////////
  // fault pin crossing

  // fault code passes the synchroniser before anything reads it
  swc_sync #(
    .W      (SWC_FAULT_W),
    .STAGES (SYNC_STAGES)
  ) u_fault_sync (
    .clk     (clk),
    .nrst    (nrst),
    .async_i (fault_code_i),
    .sync_o  (fault_q)
  );

  // previous code, for onset detection
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      fault_prev_ff <= SWC_FAULT_NONE;
    end else begin
      fault_prev_ff <= fault_q;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // bus decode

  // request stands while both cycle and strobe are high
  assign req      = wb_cyc_i && wb_stb_i;
  // first cycle of a request: answer is prepared on this edge
  assign take     = req && !ack_ff;
  // the edge at which the master samples ack is where writes land
  assign commit   = req && ack_ff && wb_we_i;
  assign hit_ctrl = swc_hit(wb_adr_i, SWC_CTRL_OFS);
  assign hit_stat = swc_hit(wb_adr_i, SWC_STAT_OFS);
  assign hit_mask = swc_hit(wb_adr_i, SWC_MASK_OFS);
  // only the low byte lane carries the control bits
  assign wr_ctrl  = commit && hit_ctrl && wb_sel_i[0];
  // reading status clears it at the sampling edge
  assign rd_stat_clr = req && ack_ff && !wb_we_i && hit_stat;

  //////////////////////////////////////////////////////////////////////////////
  // throw control register

  // only the four throw bits are stored; fault and reserved data dropped
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      close_ff <= SWC_CTRL_RST[SWC_CLOSE_LSB +: SWC_CLOSE_W];
    end else if (wr_ctrl) begin
      close_ff[0] <= wb_dat_i[SWC_CLOSE_LSB];
      close_ff[1] <= wb_dat_i[SWC_CLOSE_LSB + 1];
      close_ff[2] <= wb_dat_i[SWC_CLOSE_LSB + 2];
      close_ff[3] <= wb_dat_i[SWC_CLOSE_LSB + 3];
    end
  end

  // throw drive comes straight from the stored enables
  assign throw_one_close   = close_ff[0];
  assign throw_two_close   = close_ff[1];
  assign throw_three_close = close_ff[2];
  assign throw_four_close  = close_ff[3];

  // read view: live fault code, reserved zero, stored enables
  always_comb begin
    ctrl_view       = swc_ctrl_t'(SWC_CTRL_RST);
    ctrl_view.fault = fault_q;
    ctrl_view.rsvd  = 2'h0;
    ctrl_view.close = close_ff;
  end

  //////////////////////////////////////////////////////////////////////////////
  // mask register

  // software chooses which events raise the interrupt
  always_comb begin
    nxt_mask = mask_ff;
    // a lane-0 mask write lands at the sampling edge
    if (commit && hit_mask && wb_sel_i[0]) begin
      nxt_mask = swc_evt_t'(wb_dat_i[SWC_EVT_N-1:0]);
    end
  end

  // mask register
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      mask_ff <= swc_evt_t'(SWC_EVT_RST);
    end else begin
      mask_ff <= nxt_mask;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // events and interrupt

  // fault onset and a reserved field written nonzero
  always_comb begin
    evt         = swc_evt_t'(SWC_EVT_RST);
    evt.fault   = (fault_q != SWC_FAULT_NONE) && (fault_prev_ff == SWC_FAULT_NONE);
    evt.rsvd_wr = wr_ctrl && (wb_dat_i[SWC_RSVD_LSB +: 2] != 2'h0);
  end

  // sticky status, read clear, masked level interrupt
  // the next mask goes in so the level never lags a mask write by a cycle
  swc_irq u_irq (
    .clk      (clk),
    .nrst     (nrst),
    .evt_i    (evt),
    .rd_clr_i (rd_stat_clr),
    .mask_i   (nxt_mask),
    .stat_o   (stat),
    .irq_o    (irq)
  );

  //////////////////////////////////////////////////////////////////////////////
  // read mux and answer

  // unmapped addresses read as zero
  always_comb begin
    nxt_dat = '0;
    if (hit_ctrl) begin
      nxt_dat[7:0] = ctrl_view;
    end else if (hit_stat) begin
      nxt_dat[SWC_EVT_N-1:0] = stat;
    end else if (hit_mask) begin
      nxt_dat[SWC_EVT_N-1:0] = mask_ff;
    end
  end

  // ack one cycle after the request, dropped the cycle after
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= take;
    end
  end

  // read data captured with the ack, zero otherwise
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      dat_ff <= '0;
    end else if (take && !wb_we_i) begin
      dat_ff <= nxt_dat;
    end else begin
      dat_ff <= '0;
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = dat_ff;

  //////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  // one request is answered exactly once
  sequence req_start_s;
    req && !ack_ff;
  endsequence

  sequence ack_pulse_s;
    ack_ff ##1 !ack_ff;
  endsequence

  // fault code leaves zero: an onset event
  sequence fault_rise_s;
    (fault_q != SWC_FAULT_NONE) && (fault_prev_ff == SWC_FAULT_NONE);
  endsequence

  // status read answered with no event arriving
  sequence quiet_clear_s;
    rd_stat_clr && (evt == swc_evt_t'(SWC_EVT_RST));
  endsequence

  // control write carrying nonzero reserved data
  sequence rsvd_write_s;
    wr_ctrl && (wb_dat_i[SWC_RSVD_LSB +: 2] != 2'h0);
  endsequence

  // throw enables, answer and interrupt start at zero when reset lets go
  reset_clear_a: assert property ($rose(nrst) |-> close_ff == 4'h0 && !ack_ff && !irq)
    else $error("throw enables not zero after reset");

  // a control write at offset 0x20 lands bit 0 on throw one
  throw_one_a: assert property (wr_ctrl |=> throw_one_close == $past(wb_dat_i[0]))
    else $error("throw one did not follow bit 0");

  // bit 1 reaches throw two
  throw_two_a: assert property (wr_ctrl |=> throw_two_close == $past(wb_dat_i[1]))
    else $error("throw two did not follow bit 1");

  // bit 2 reaches throw three
  throw_three_a: assert property (wr_ctrl |=> throw_three_close == $past(wb_dat_i[2]))
    else $error("throw three did not follow bit 2");

  // bit 3 reaches throw four
  throw_four_a: assert property (wr_ctrl |=> throw_four_close == $past(wb_dat_i[3]))
    else $error("throw four did not follow bit 3");

  // fault field returns the synchronised code of the taking cycle
  fault_read_a: assert property (
    req_start_s ##0 (!wb_we_i && hit_ctrl) |=> wb_dat_o[7:6] == $past(fault_q))
    else $error("fault field read wrong");

  // reserved field always reads zero
  rsvd_zero_a: assert property (ack_ff |-> wb_dat_o[5:4] == 2'h0)
    else $error("reserved field read nonzero");

  // throws move only on a lane-0 control write
  throw_hold_a: assert property (!wr_ctrl |=> $stable(close_ff))
    else $error("throws changed without a control write");

  // answer follows a fresh request by one cycle and lasts one
  ack_once_a: assert property (req_start_s |=> ack_pulse_s)
    else $error("ack not a single pulse after request");

  // interrupt tracks masked status
  irq_level_a: assert property (irq == |(stat & mask_ff))
    else $error("interrupt level mismatch");

  // a status read with no event arriving leaves status clear
  stat_clear_a: assert property (quiet_clear_s |=> stat == swc_evt_t'(SWC_EVT_RST))
    else $error("status not cleared by its read");

  // an onset on the clearing edge still sets the status bit
  set_wins_a: assert property (rd_stat_clr && evt.fault |=> stat.fault)
    else $error("fault onset lost to a status read");

  // a fault onset sets its status bit one edge later
  fault_onset_a: assert property (fault_rise_s |=> stat.fault)
    else $error("fault onset not recorded");

  // reserved data written nonzero is reported, never stored
  rsvd_event_a: assert property (rsvd_write_s |=> stat.rsvd_wr)
    else $error("reserved write not reported");

  // read data stays zero whenever no answer stands
  dat_idle_a: assert property (!ack_ff |-> wb_dat_o == '0)
    else $error("read data not zero outside an answer");

  // a lane-0 mask write lands the low data bits
  mask_write_a: assert property (
    commit && hit_mask && wb_sel_i[0] |=> mask_ff == $past(wb_dat_i[SWC_EVT_N-1:0]))
    else $error("mask write did not land");

endmodule

/* File: bench/swc_regs_tb.sv */
// self-checking bench for the throw control register block
`timescale 1ns/1ns
module swc_regs_tb
  import swc_pkg::*;
;
  //////////////////////////////////////////////////////////////////////////////
  // stimulus and observed signals
  logic                 clk;             // 100 MHz clock
  logic                 nrst;            // async reset, active low
  logic                 wb_cyc;          // bus cycle
  logic                 wb_stb;          // bus strobe
  logic                 wb_we;           // write when high
  logic [SWC_ADR_W-1:0] wb_adr;          // byte address
  logic [SWC_SEL_W-1:0] wb_sel;          // byte selects
  logic [SWC_DAT_W-1:0] wb_wdat;         // write data
  logic [SWC_DAT_W-1:0] wb_rdat;         // read data
  logic                 wb_ack;          // answer
  logic [1:0]           fault_code;      // fault pins
  logic [4:0]           pins;            // irq and four throws
  logic                 t1, t2, t3, t4;  // throw drives
  logic                 irq;             // interrupt level
  logic [SWC_DAT_W-1:0] exp_q[$];        // expected read data, oldest first
  int                   fails;           // mismatches seen
  int                   checks_done;     // comparisons made
  int                   cycles;          // timeout counter
  logic [31:0]          seed;            // xorshift state
  logic [3:0]           cur;             // expected throw bits

  assign pins = {irq, t4, t3, t2, t1};

  //////////////////////////////////////////////////////////////////////////////
  // design under test
  swc_regs #(.SYNC_STAGES(SWC_SYNC_STAGES)) DUT (
    .clk(clk), .nrst(nrst),
    .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
    .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack),
    .fault_code_i(fault_code),
    .throw_one_close(t1), .throw_two_close(t2),
    .throw_three_close(t3), .throw_four_close(t4), .irq(irq)
  );

  //////////////////////////////////////////////////////////////////////////////
  // clock generator
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // closing report, the only place the run ends
  task automatic stop_test();
    if (fails == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // compare read data
  task automatic chk_rd(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("FAIL t=%0t rdata got=%h exp=%h", $time, got, exp);
    end
  endtask

  // compare interrupt and throw pins
  task automatic chk_pin(input logic [4:0] exp);
    checks_done++;
    if (pins !== exp) begin
      fails++;
      $display("FAIL t=%0t pins got=%h exp=%h", $time, pins, exp);
    end
  endtask

  // xorshift generator
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    x = x ^ (x << 5);
    return x;
  endfunction

  // one classic cycle: hold until ack sampled, then release for one cycle
  task automatic wb_xfer(input logic w, input logic [7:0] a, input logic [3:0] s,
                         input logic [31:0] d);
    wb_cyc  <= 1'b1;
    wb_stb  <= 1'b1;
    wb_we   <= w;
    wb_adr  <= a;
    wb_sel  <= s;
    wb_wdat <= d;
    do @(posedge clk); while (wb_ack !== 1'b1);
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we  <= 1'b0;
    @(posedge clk);
  endtask

  // read with its expectation noted first
  task automatic wb_read(input logic [7:0] a, input logic [31:0] exp);
    exp_q.push_back(exp);
    wb_xfer(1'b0, a, 4'hF, 32'h0000_0000);
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // watcher: each read answer takes the oldest note
  always @(posedge clk) begin
    if (wb_ack === 1'b1 && wb_we === 1'b0) begin
      if (exp_q.size() == 0) begin
        fails++;
        $display("FAIL t=%0t unexpected ack got=%h exp=%h", $time, wb_rdat, 32'h0);
      end else begin
        chk_rd(wb_rdat, exp_q.pop_front());
      end
    end
  end

  // hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles > 5000) begin
      fails++;
      stop_test();
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    {wb_cyc, wb_stb, wb_we} = 3'h0;
    wb_adr      = 8'h00;
    wb_sel      = 4'h0;
    wb_wdat     = 32'h0000_0000;
    fault_code  = 2'h0;
    nrst        = 1'b0;
    fails       = 0;
    checks_done = 0;
    cycles      = 0;
    seed        = 32'h0000_0006;
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    chk_pin(5'h00);
    wb_read(SWC_CTRL_OFS, 32'h0000_0000);
    // walk each throw bit alone
    for (int i = 0; i < 4; i++) begin
      cur = 4'h1 << i;
      wb_xfer(1'b1, SWC_CTRL_OFS, 4'hF, {28'h0, cur});
      chk_pin({1'b0, cur});
      wb_read(SWC_CTRL_OFS, {28'h0, cur});
    end
    // all ones: only throw bits land, masked event keeps irq low
    wb_xfer(1'b1, SWC_MASK_OFS, 4'hF, 32'h0000_0000);
    wb_xfer(1'b1, SWC_CTRL_OFS, 4'hF, 32'h0000_00FF);
    wb_read(SWC_CTRL_OFS, 32'h0000_000F);
    chk_pin(5'h0F);
    wb_xfer(1'b1, SWC_MASK_OFS, 4'hF, 32'h0000_0002);
    @(posedge clk);
    chk_pin(5'h1F);
    wb_read(SWC_STAT_OFS, 32'h0000_0002);
    @(posedge clk);
    chk_pin(5'h0F);
    // low byte not selected, then an unmapped place
    wb_xfer(1'b1, SWC_CTRL_OFS, 4'hE, 32'h0000_0000);
    wb_read(SWC_CTRL_OFS, 32'h0000_000F);
    wb_xfer(1'b1, 8'h30, 4'hF, 32'h0000_0000);
    wb_read(8'h30, 32'h0000_0000);
    wb_read(SWC_CTRL_OFS, 32'h0000_000F);
    // every nonzero fault code, each an onset from zero
    wb_xfer(1'b1, SWC_MASK_OFS, 4'hF, 32'h0000_0001);
    for (int c = 1; c < 4; c++) begin
      fault_code <= c[1:0];
      repeat (4) @(posedge clk);
      chk_pin(5'h1F);
      wb_read(SWC_CTRL_OFS, {24'h0, c[1:0], 6'h0F});
      wb_read(SWC_STAT_OFS, 32'h0000_0001);
      fault_code <= 2'h0;
      repeat (4) @(posedge clk);
      wb_read(SWC_STAT_OFS, 32'h0000_0000);
      wb_read(SWC_CTRL_OFS, 32'h0000_000F);
    end
    // onset lands on the edge that clears status: the event wins
    fault_code <= 2'h1;
    @(posedge clk);
    wb_read(SWC_STAT_OFS, 32'h0000_0000);
    wb_read(SWC_STAT_OFS, 32'h0000_0001);
    fault_code <= 2'h0;
    // random writes, host keeps the reserved pair zero
    cur = 4'hF;
    repeat (24) begin
      seed = xs(seed);
      if (seed[8]) begin
        cur = seed[3:0];
      end
      wb_xfer(1'b1, SWC_CTRL_OFS, seed[11:8], {24'h0, seed[7:6], 2'h0, seed[3:0]});
      chk_pin({1'b0, cur});
      wb_read(SWC_CTRL_OFS, {28'h0, cur});
    end
    // second reset in mid-run
    wb_xfer(1'b1, SWC_CTRL_OFS, 4'hF, 32'h0000_000A);
    nrst <= 1'b0;
    @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    chk_pin(5'h00);
    wb_read(SWC_CTRL_OFS, 32'h0000_0000);
    repeat (2) @(posedge clk);
    stop_test();
  end
endmodule
